// ===== logic/cpd_consts.svh
/*
 * Offsets, field positions, reset values and counts of the clock and power-down controller.
 * Assumes a 32-bit register bus with one aligned word per register.
 */
`ifndef CPD_CONSTS_SVH
`define CPD_CONSTS_SVH

`define CPD_OFS_PDC 8'h00
`define CPD_OFS_AHB 8'h04
`define CPD_OFS_APB 8'h08
`define CPD_OFS_STS 8'h0c
`define CPD_OFS_SEL0 8'h10
`define CPD_OFS_SEL1 8'h14
`define CPD_OFS_CDIV 8'h18
`define CPD_OFS_SEL2 8'h1c
`define CPD_OFS_PLL 8'h20
`define CPD_OFS_FRQ 8'h24

`define CPD_PDC_XTAL 0
`define CPD_PDC_FOSC 2
`define CPD_PDC_SOSC 3
`define CPD_PDC_WDLY 4
`define CPD_PDC_WIE 5
`define CPD_PDC_WSTS 6
`define CPD_PDC_PWRDN 7
`define CPD_PDC_WFS 8
`define CPD_APB_WDOG 0
`define CPD_FRQ_RUN 4

`define CPD_RST_WDLY 1'h1
`define CPD_RST_SOSC 1'h1
`define CPD_RST_FOSC 1'h1
`define CPD_RST_AHB 32'h0000000d
`define CPD_RST_APB 32'h00000000
`define CPD_RST_SEL1 32'hffffffff
`define CPD_RST_CDIV 32'h00000000
`define CPD_RST_SEL2 32'h000000ff
`define CPD_RST_PLL 32'h0005c22e
`define CPD_RST_FRQ 5'h00
`define CPD_RST_TICK 3'h7

`define CPD_SRC_XTAL 3'h0
`define CPD_SRC_SLOW 3'h3
`define CPD_WAKE_XTAL 4096
`define CPD_WAKE_FAST 256

`define CPD_RESP_OKAY 2'h0
`define CPD_RESP_SLVERR 2'h2

`endif

// ===== logic/cpd_pkg.sv
/*
 * Types of the clock and power-down controller: power state and the packed state record.
 * Assumes cpd_consts.svh supplies all numbers.
 */
package cpd_pkg;

	typedef logic [2:0] cpd_sel_t;

	typedef enum logic [1:0] {
		CPD_RUN = 2'b00,
		CPD_IDLE = 2'b01,
		CPD_PDOWN = 2'b10,
		CPD_WAKE = 2'b11
	} cpd_state_t;

	typedef struct packed {
		cpd_state_t st;
		logic [12:0] wcnt;
		logic loaded;
		logic arm;
		logic wfs;
		logic wsts;
		logic wie;
		logic wdly;
		logic sosc;
		logic fosc;
		logic xtal;
		logic [5:0] sel0;
		logic [31:0] ahb;
		logic [31:0] apb;
		logic [31:0] sel1;
		logic [31:0] cdiv;
		logic [31:0] sel2;
		logic [31:0] pll;
		logic [4:0] frq;
		logic [15:0] chain;
		logic drun;
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic xtal_on;
		logic fosc_on;
		logic sosc_on;
		logic pll_on;
		logic sys_en;
		logic cpu_en;
		cpd_sel_t sys_src;
		logic [31:0] ahb_gate;
		logic [31:0] apb_gate;
		logic tick_ext;
		cpd_sel_t tick_src;
		logic irq;
		logic div_pin;
		logic pd;
	} cpd_regs_t;

endpackage : cpd_pkg

// ===== logic/cpd_top.sv
/*
 * Clock and power-down controller: source enables, system and tick clock selection,
 * power-down and idle sequencing, wake-up delay, wake flag and interrupt, power-of-two divider.
 * Assumes an AXI4-Lite master, a core sleep level, wake events and unlock level synchronous to aclk.
 */
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "cpd_consts.svh"

// What this block does
// RULE1: power-down stops the crystal and the fast oscillator.
// RULE2: power-down leaves the slow oscillator running.
// RULE3: power-down stops PLL and system clock, freezes source selection until wake.
// RULE4: with wait-select set, power-down needs arm bit and core sleep.
// RULE5: with wait-select clear, power-down follows the arm bit at once.
// RULE6: wake-up clears the arm bit; software re-arms for the next time.
// RULE7: optional wake delay of 4096 crystal or 256 fast-oscillator cycles.
// RULE8: a wake event out of power-down sets the wake flag.
// RULE9: writing 1 clears the wake flag, writing 0 keeps it.
// RULE10: wake interrupt is flag AND enable.
// RULE11: oscillator enable bits switch sources; they are write-protected.
// RULE12: crystal enable loads from the boot source; forced on for crystal boot.
// RULE13: arm, wait-select, interrupt enable and delay enable need unlock.
// RULE14: core sleep with arm clear gates only the core clock.
// RULE15: in power-down only the watchdog keeps its clock.
// RULE16: system clock source comes from select field bits 2..0.
// RULE17: tick runs on core clock or external tick, source from bits 5..3.
// RULE18: sixteen divide-by-two stages, one tapped by a 16:1 mux.
// RULE19: divider output is input over two to the tap plus one.
// RULE20: run bit starts the chain; clearing stops it once output is low.
// RULE21: software unlocks protection before touching protected bits.
// RULE22: system clock stays gated until the wake counter expires.
module cpd_top #(
	parameter logic [12:0] WAKE_XTAL_CYC = 13'(`CPD_WAKE_XTAL),
	parameter logic [12:0] WAKE_FAST_CYC = 13'(`CPD_WAKE_FAST)
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// boot strap and protection
	input wire cpd_pkg::cpd_sel_t boot_clk_src,
	input wire logic prot_unlocked,
	// core side
	input wire logic cpu_sleeping,
	input wire logic tick_core_clk_sel,
	input wire logic wake_event,
	// oscillator status
	input wire logic xtal_stable,
	input wire logic fast_osc_stable,
	input wire logic slow_osc_stable,
	input wire logic pll_stable,
	// clock controls
	output logic crystal_on,
	output logic fast_osc_on,
	output logic slow_osc_on,
	output logic pll_on,
	output logic sys_clk_en,
	output logic cpu_clk_en,
	output cpd_pkg::cpd_sel_t sys_clk_src,
	output logic [31:0] ahb_clk_gate,
	output logic [31:0] apb_clk_gate,
	output logic tick_use_external,
	output cpd_pkg::cpd_sel_t tick_clk_src,
	output logic in_power_down,
	output logic wake_irq,
	output logic divider_output_pin
);
	import cpd_pkg::*;

	cpd_regs_t r;
	cpd_regs_t n;

	// one toggle enable per divide-by-two stage; a stage flips when all below it are high
	wire logic [15:0] stage_flip;

	for (genvar gi = 0; gi < 16; gi++) begin : g_stage
		if (gi == 0) begin : g_first
			assign stage_flip[gi] = r.drun; // [RULE18]
		end else begin : g_rest
			assign stage_flip[gi] = stage_flip[gi - 1] && r.chain[gi - 1];
		end
	end

	// watchdog runs from the slow oscillator, so its gate alone survives power-down
	localparam logic [31:0] PD_APB_KEEP = 32'h00000001 << `CPD_APB_WDOG;

	// byte lanes follow wstrb
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	// {hit, word} for one register address
	function automatic logic [32:0] peek(input logic [7:0] a);
		logic [32:0] res;
		res = {1'b1, 32'h0};
		case ({a[7:2], 2'b00})
			`CPD_OFS_PDC: res[31:0] = {23'h0, r.wfs, r.arm, r.wsts, r.wie, r.wdly, r.sosc, r.fosc, 1'b0, r.xtal};
			`CPD_OFS_AHB: res[31:0] = r.ahb;
			`CPD_OFS_APB: res[31:0] = r.apb;
			// status bits come straight from the oscillator inputs
			`CPD_OFS_STS: res[31:0] = {27'h0, fast_osc_stable, slow_osc_stable, pll_stable, 1'b0, xtal_stable};
			`CPD_OFS_SEL0: res[31:0] = {26'h0, r.sel0};
			`CPD_OFS_SEL1: res[31:0] = r.sel1;
			`CPD_OFS_CDIV: res[31:0] = r.cdiv;
			`CPD_OFS_SEL2: res[31:0] = r.sel2;
			`CPD_OFS_PLL: res[31:0] = r.pll;
			`CPD_OFS_FRQ: res[31:0] = {27'h0, r.frq};
			default: res = 33'h0;
		endcase
		return res;
	endfunction : peek

	always_comb begin
		logic [32:0] hit;
		logic [31:0] m;
		logic do_wr;
		logic asleep;
		logic [15:0] nchain;
		hit = 33'h0;
		m = 32'h0;
		do_wr = 1'b0;
		asleep = 1'b0;
		nchain = 16'h0;
		n = r;

		// bus write channel: address and data in either order
		if (s_axi_awvalid && r.awready) begin
			n.aw_got = 1'b1;
			n.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && r.wready) begin
			n.w_got = 1'b1;
			n.wdata = s_axi_wdata;
			n.wstrb = s_axi_wstrb;
		end
		if (r.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		do_wr = r.aw_got && r.w_got && !r.bvalid;
		if (do_wr) begin
			hit = peek(r.awaddr);
			m = merge(hit[31:0], r.wdata, r.wstrb);
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = hit[32] ? `CPD_RESP_OKAY : `CPD_RESP_SLVERR;
			case ({r.awaddr[7:2], 2'b00})
				`CPD_OFS_PDC: begin
					// lock keeps a stray write from stopping the clocks
					if (prot_unlocked) begin
						n.wfs = m[`CPD_PDC_WFS]; // [RULE13]
						n.arm = m[`CPD_PDC_PWRDN]; // [RULE13]
						n.wie = m[`CPD_PDC_WIE];
						n.wdly = m[`CPD_PDC_WDLY];
						n.sosc = m[`CPD_PDC_SOSC]; // [RULE11]
						n.fosc = m[`CPD_PDC_FOSC];
						n.xtal = m[`CPD_PDC_XTAL];
					end
					// clear needs no unlock; a wake in the same cycle sets it again below
					if (r.wstrb[0] && r.wdata[`CPD_PDC_WSTS]) begin
						n.wsts = 1'b0; // [RULE9]
					end
				end
				`CPD_OFS_AHB: n.ahb = m;
				`CPD_OFS_APB: begin
					n.apb = m;
					if (!prot_unlocked) begin
						n.apb[`CPD_APB_WDOG] = r.apb[`CPD_APB_WDOG];
					end
				end
				`CPD_OFS_SEL0: begin
					if (prot_unlocked) begin
						n.sel0 = m[5:0];
					end
				end
				`CPD_OFS_SEL1: n.sel1 = m;
				`CPD_OFS_CDIV: n.cdiv = m;
				`CPD_OFS_SEL2: n.sel2 = m;
				`CPD_OFS_PLL: n.pll = m;
				`CPD_OFS_FRQ: n.frq = m[4:0];
				default: n.bresp = `CPD_RESP_SLVERR;
			endcase
		end

		// bus read: data registered with rvalid
		if (r.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (s_axi_arvalid && r.arready) begin
			hit = peek(s_axi_araddr);
			n.rvalid = 1'b1;
			n.rdata = hit[31:0];
			n.rresp = hit[32] ? `CPD_RESP_OKAY : `CPD_RESP_SLVERR;
		end
		n.awready = !n.aw_got && !n.bvalid;
		n.wready = !n.w_got && !n.bvalid;
		// one read in flight, so rdata cannot move under the master
		n.arready = !n.rvalid;

		// boot source caught once after reset release, never inside reset
		if (!r.loaded) begin
			n.loaded = 1'b1;
			n.sel0[2:0] = boot_clk_src;
			n.xtal = (boot_clk_src == `CPD_SRC_XTAL); // [RULE12]
		end

		// power state sequencing
		case (r.st)
			CPD_RUN, CPD_IDLE: begin
				if (n.arm && (!n.wfs || cpu_sleeping)) begin
					n.st = CPD_PDOWN; // [RULE4] [RULE5]
				end else if (cpu_sleeping) begin
					n.st = CPD_IDLE; // [RULE14]
				end else begin
					n.st = CPD_RUN;
				end
			end
			CPD_PDOWN: begin
				if (wake_event) begin
					n.arm = 1'b0; // [RULE6]
					n.wsts = 1'b1; // [RULE8]
					if (r.wdly && r.sys_src != `CPD_SRC_SLOW) begin
						n.st = CPD_WAKE;
						n.wcnt = r.sys_src[2] ? WAKE_FAST_CYC : WAKE_XTAL_CYC; // [RULE7]
					end else begin
						n.st = CPD_RUN;
					end
				end
			end
			CPD_WAKE: begin
				// counted on aclk as a stand-in for the restarting oscillator
				if (r.wcnt <= 13'h1) begin
					n.st = CPD_RUN; // [RULE22]
					n.wcnt = 13'h0;
				end else begin
					n.wcnt = r.wcnt - 13'h1;
				end
			end
			default: n.st = CPD_RUN;
		endcase

		// divider chain: stage i toggles when all lower stages are high
		nchain = r.chain ^ stage_flip; // [RULE18]
		n.chain = nchain;
		// stopping only on a low tap keeps a runt pulse off the pin
		n.drun = n.frq[`CPD_FRQ_RUN] || (r.drun && nchain[n.frq[3:0]]); // [RULE20]
		n.div_pin = (r.drun || n.drun) && nchain[n.frq[3:0]]; // [RULE19]

		// clock outputs follow the next state, so they change with it
		asleep = (n.st == CPD_PDOWN) || (n.st == CPD_WAKE);
		n.pd = n.st == CPD_PDOWN;
		n.xtal_on = n.xtal && !n.pd; // [RULE1]
		n.fosc_on = n.fosc && !n.pd; // [RULE1]
		n.sosc_on = n.sosc; // [RULE2]
		n.pll_on = !n.pd; // [RULE3]
		n.sys_en = !asleep; // [RULE3] [RULE22]
		n.cpu_en = n.st == CPD_RUN; // [RULE14]
		// holding the old source across sleep avoids a switch onto a stopped oscillator
		n.sys_src = asleep ? r.sys_src : n.sel0[2:0]; // [RULE3] [RULE16]
		n.ahb_gate = asleep ? 32'h0 : n.ahb; // [RULE15]
		n.apb_gate = asleep ? (n.apb & PD_APB_KEEP) : n.apb; // [RULE15]
		n.tick_ext = !tick_core_clk_sel; // [RULE17]
		n.tick_src = n.sel0[5:3]; // [RULE17]
		// registered from the next flag and enable, so it changes on the same edge as they do
		n.irq = n.wsts && n.wie; // [RULE10]
	end

	always_ff @(posedge aclk) begin
		// strap-dependent bits are loaded one edge after release
		if (!aresetn) begin
			r <= '0;
			r.st <= CPD_RUN;
			r.wdly <= `CPD_RST_WDLY;
			r.sosc <= `CPD_RST_SOSC;
			r.fosc <= `CPD_RST_FOSC;
			r.sel0 <= {`CPD_RST_TICK, `CPD_SRC_XTAL};
			r.ahb <= `CPD_RST_AHB;
			r.apb <= `CPD_RST_APB;
			r.sel1 <= `CPD_RST_SEL1;
			r.cdiv <= `CPD_RST_CDIV;
			r.sel2 <= `CPD_RST_SEL2;
			r.pll <= `CPD_RST_PLL;
			r.frq <= `CPD_RST_FRQ;
			r.sosc_on <= `CPD_RST_SOSC;
		end else begin
			r <= n;
		end
	end

	// bus answers
	assign s_axi_awready = r.awready;
	assign s_axi_wready = r.wready;
	assign s_axi_bvalid = r.bvalid;
	assign s_axi_bresp = r.bresp;
	assign s_axi_arready = r.arready;
	assign s_axi_rvalid = r.rvalid;
	assign s_axi_rdata = r.rdata;
	assign s_axi_rresp = r.rresp;

	// clock controls
	assign crystal_on = r.xtal_on;
	assign fast_osc_on = r.fosc_on;
	assign slow_osc_on = r.sosc_on;
	assign pll_on = r.pll_on;
	assign sys_clk_en = r.sys_en;
	assign cpu_clk_en = r.cpu_en;
	assign sys_clk_src = r.sys_src;
	assign ahb_clk_gate = r.ahb_gate;
	assign apb_clk_gate = r.apb_gate;
	assign tick_use_external = r.tick_ext;
	assign tick_clk_src = r.tick_src;
	assign in_power_down = r.pd;
	assign wake_irq = r.irq;
	assign divider_output_pin = r.div_pin;

endmodule : cpd_top

// ===== verification/cpd_assertions.sv
/*
 * Port-level checks of the clock and power-down controller.
 * Assumes it is bound to cpd_top and sees only its ports.
 */
`timescale 1ns/1ps
module cpd_assertions (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bus answers
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// core side
	input wire logic tick_core_clk_sel,
	input wire logic cpu_sleeping,
	input wire logic wake_event,
	// clock controls
	input wire logic crystal_on,
	input wire logic fast_osc_on,
	input wire logic pll_on,
	input wire logic sys_clk_en,
	input wire logic cpu_clk_en,
	input wire logic [2:0] sys_clk_src,
	input wire logic [31:0] ahb_clk_gate,
	input wire logic [31:0] apb_clk_gate,
	input wire logic tick_use_external,
	input wire logic in_power_down
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	AST_PD_OSC: assert property (in_power_down |-> !crystal_on && !fast_osc_on)
		else $error("fast source on in power-down");
	AST_PD_SYS: assert property (in_power_down |-> !pll_on && !sys_clk_en)
		else $error("pll or system clock on in power-down");
	AST_PD_GATE: assert property (in_power_down |-> ahb_clk_gate == 32'h0 && apb_clk_gate[31:1] == 31'h0)
		else $error("peripheral clock on in power-down");
	AST_WAKE: assert property (in_power_down && wake_event |=> !in_power_down)
		else $error("wake event ignored");
	AST_TICK: assert property ($past(aresetn) |-> tick_use_external == !$past(tick_core_clk_sel))
		else $error("tick source wrong");
	AST_IDLE: assert property (sys_clk_en && !cpu_clk_en |-> $past(cpu_sleeping))
		else $error("core clock gated without sleep");
	AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	AST_PD_CPU: assert property (in_power_down |-> !cpu_clk_en)
		else $error("core clock on in power-down");
	AST_PD_SRC: assert property (in_power_down |-> $stable(sys_clk_src))
		else $error("system source moved in power-down");
endmodule : cpd_assertions

bind cpd_top cpd_assertions chk_u (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .tick_core_clk_sel, .cpu_sleeping, .wake_event,
	.crystal_on, .fast_osc_on, .pll_on, .sys_clk_en, .cpu_clk_en, .sys_clk_src, .ahb_clk_gate, .apb_clk_gate,
	.tick_use_external, .in_power_down);

// ===== verification/cpd_far_model.sv
/*
 * Core and oscillator model: sleep level, wake event, stability flags.
 * Assumes the bench commands sleep and wake on aclk.
 */
`timescale 1ns/1ps
module cpd_far_model (
	// clock and commands
	input wire logic aclk,
	input wire logic sleep_cmd,
	input wire logic wake_cmd,
	// enables
	input wire logic crystal_on,
	input wire logic fast_osc_on,
	input wire logic slow_osc_on,
	input wire logic pll_on,
	// answers
	output logic cpu_sleeping = 1'b0,
	output logic wake_event = 1'b0,
	output logic xtal_stable = 1'b0,
	output logic fast_osc_stable = 1'b0,
	output logic slow_osc_stable = 1'b0,
	output logic pll_stable = 1'b0
);
	// stability lags the enable by a cycle, never ahead of it
	always @(posedge aclk) begin
		cpu_sleeping <= sleep_cmd;
		wake_event <= wake_cmd;
		xtal_stable <= crystal_on;
		fast_osc_stable <= fast_osc_on;
		slow_osc_stable <= slow_osc_on;
		pll_stable <= pll_on;
	end
endmodule : cpd_far_model

// ===== verification/tb.sv
/*
 * Self-checking bench of the clock and power-down controller.
 * Assumes cpd_far_model and the bound checker; short wake counts.
 */
`timescale 1ns/1ps
`include "cpd_consts.svh"
module tb;
	import cpd_pkg::*;
	localparam int WX = 8;
	localparam int WF = 4;
	logic aclk = 0, aresetn = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, ahb_clk_gate, apb_clk_gate;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	cpd_sel_t boot_clk_src = 0, sys_clk_src, tick_clk_src;
	logic prot_unlocked = 1, tick_core_clk_sel = 1, sleep_cmd = 0, wake_cmd = 0;
	logic cpu_sleeping, wake_event, xtal_stable, fast_osc_stable, slow_osc_stable, pll_stable;
	logic crystal_on, fast_osc_on, slow_osc_on, pll_on, sys_clk_en, cpu_clk_en;
	logic tick_use_external, in_power_down, wake_irq, divider_output_pin;
	logic [31:0] d;
	logic [1:0] r, b;
	int num_errors = 0, n_compared = 0;

	always #10 aclk = ~aclk;

	cpd_top #(.WAKE_XTAL_CYC(13'(WX)), .WAKE_FAST_CYC(13'(WF))) dut_u (.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .boot_clk_src, .prot_unlocked, .cpu_sleeping,
		.tick_core_clk_sel, .wake_event, .xtal_stable, .fast_osc_stable, .slow_osc_stable,
		.pll_stable, .crystal_on, .fast_osc_on, .slow_osc_on, .pll_on, .sys_clk_en,
		.cpu_clk_en, .sys_clk_src, .ahb_clk_gate, .apb_clk_gate, .tick_use_external,
		.tick_clk_src, .in_power_down, .wake_irq, .divider_output_pin);

	cpd_far_model far_u (.aclk, .sleep_cmd, .wake_cmd, .crystal_on, .fast_osc_on,
		.slow_osc_on, .pll_on, .cpu_sleeping, .wake_event, .xtal_stable,
		.fast_osc_stable, .slow_osc_stable, .pll_stable);

	task automatic end_of_test();
		if (num_errors == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s exp %h got %h", s, e, g);
		end
	endtask : chk

	task automatic cy(input int n);
		repeat (n) @(posedge aclk);
		#1;
	endtask : cy

	// address and data released each at its own taking edge
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		b = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd

	// returns edges from leaving power-down until the system clock is back
	task automatic wake(output int n);
		wake_cmd = 1'b1;
		do cy(1);
		while (in_power_down !== 1'b0);
		wake_cmd = 1'b0;
		n = 0;
		while (sys_clk_en !== 1'b1) begin
			cy(1);
			n++;
		end
	endtask : wake

	task automatic t_rst();
		logic [31:0] rv [9] = '{32'h1d, 32'hd, 32'h0, 32'h38, 32'hffffffff, 32'h0, 32'hff, 32'h0005c22e, 32'h0};
		for (int i = 0; i < 9; i++) begin
			rd(8'((i < 3) ? i * 4 : i * 4 + 4));
			chk("reset value", rv[i], d);
		end
		rd(8'h28);
		chk("unmapped resp", `CPD_RESP_SLVERR, r);
		rd(`CPD_OFS_STS);
		chk("stable flags", 32'h1d, d);
		wr(8'h28, 32'h0);
		chk("unmapped write resp", `CPD_RESP_SLVERR, b);
	endtask : t_rst

	task automatic t_prot();
		@(posedge aclk) prot_unlocked <= 1'b0;
		wr(`CPD_OFS_PDC, 32'h1bd);
		chk("locked write resp", `CPD_RESP_OKAY, b);
		cy(3);
		chk("locked entry", 0, in_power_down);
		rd(`CPD_OFS_PDC);
		chk("locked control", 32'h1d, d);
		@(posedge aclk) prot_unlocked <= 1'b1;
		wr(`CPD_OFS_PDC, 32'h19);
		cy(2);
		chk("fast osc off", 0, fast_osc_on);
		wr(`CPD_OFS_PDC, 32'h1d);
		cy(2);
		chk("fast osc on", 1, fast_osc_on);
	endtask : t_prot

	task automatic t_pd_now();
		int n;
		wr(`CPD_OFS_APB, 32'h41);
		wr(`CPD_OFS_PDC, 32'h9d);
		cy(2);
		chk("entry", 1, in_power_down);
		chk("slow osc", 1, slow_osc_on);
		chk("fast sources", 0, {crystal_on, fast_osc_on});
		chk("pll and system", 0, {pll_on, sys_clk_en, cpu_clk_en});
		chk("watchdog clock", 32'h1, apb_clk_gate);
		chk("ahb clocks", 0, ahb_clk_gate);
		wake(n);
		chk("wake delay", WX, n);
		chk("apb after wake", 32'h41, apb_clk_gate);
		rd(`CPD_OFS_PDC);
		chk("arm cleared, flag set", 32'h5d, d);
		wr(`CPD_OFS_PDC, 32'h3d);
		cy(2);
		chk("irq", 1, wake_irq);
		wr(`CPD_OFS_PDC, 32'h7d);
		cy(2);
		chk("irq clear", 0, wake_irq);
		rd(`CPD_OFS_PDC);
		chk("flag clear", 32'h3d, d);
	endtask : t_pd_now

	task automatic t_pd_wait();
		int n;
		wr(`CPD_OFS_PDC, 32'h19d);
		cy(3);
		chk("wait for sleep", 0, in_power_down);
		sleep_cmd = 1'b1;
		cy(3);
		chk("sleep entry", 1, in_power_down);
		wake(n);
		sleep_cmd = 1'b0;
		chk("wake delay again", WX, n);
	endtask : t_pd_wait

	task automatic t_idle();
		wr(`CPD_OFS_PDC, 32'h1d);
		sleep_cmd = 1'b1;
		cy(3);
		chk("idle core", 0, cpu_clk_en);
		chk("idle system", 1, sys_clk_en);
		sleep_cmd = 1'b0;
		cy(3);
		chk("idle exit", 1, cpu_clk_en);
	endtask : t_idle

	task automatic t_sel();
		wr(`CPD_OFS_SEL0, 32'h13);
		@(posedge aclk) tick_core_clk_sel <= 1'b0;
		cy(2);
		chk("system source", `CPD_SRC_SLOW, sys_clk_src);
		chk("tick source", 3'h2, tick_clk_src);
		chk("tick external", 1, tick_use_external);
	endtask : t_sel

	task automatic t_pd_fast();
		int n;
		wr(`CPD_OFS_SEL0, 32'h3f);
		wr(`CPD_OFS_PDC, 32'h9d);
		cy(2);
		chk("fast entry", 1, in_power_down);
		wr(`CPD_OFS_SEL0, 32'h3b);
		cy(2);
		chk("source frozen", 3'h7, sys_clk_src);
		wake(n);
		chk("fast wake delay", WF, n);
		chk("source after wake", `CPD_SRC_SLOW, sys_clk_src);
	endtask : t_pd_fast

	task automatic t_div();
		int n;
		wr(`CPD_OFS_FRQ, 32'h12);
		do cy(1);
		while (divider_output_pin !== 1'b1);
		n = 0;
		while (divider_output_pin === 1'b1) begin
			cy(1);
			n++;
		end
		chk("divider half period", 4, n);
		wr(`CPD_OFS_FRQ, 32'h02);
		cy(16);
		n = 0;
		repeat (16) begin
			cy(1);
			n += (divider_output_pin !== 1'b0);
		end
		chk("divider stopped low", 0, n);
	endtask : t_div

	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		t_rst();
		t_prot();
		t_pd_now();
		t_pd_wait();
		t_idle();
		t_sel();
		t_pd_fast();
		t_div();
		end_of_test();
	end

	// whole run needs a few hundred cycles
	initial begin
		#400000;
		num_errors++;
		end_of_test();
	end
endmodule : tb
